// File: include/pph_defines.svh
// Offsets, control word fields, pin positions and reset values
// Included by pph_top and the testbench; definitions only
`ifndef PPH_DEFINES_SVH
`define PPH_DEFINES_SVH

`define PPH_OFF_PORT_A   8'h00
`define PPH_OFF_PORT_B   8'h04
`define PPH_OFF_PORT_C   8'h08
`define PPH_OFF_CTRL     8'h0c
`define PPH_OFF_INT_CTRL 8'h10
`define PPH_OFF_EV_STAT  8'h14
`define PPH_OFF_EV_MASK  8'h18

`define PPH_CW_MODESET   7
`define PPH_CW_VAL       0
`define PPH_CTRL_RST     8'h9b

`define PPH_PC_OBF_A     7
`define PPH_PC_ACK_A     6
`define PPH_PC_IBF_A     5
`define PPH_PC_STB_A     4
`define PPH_PC_INTR_A    3
`define PPH_PC_HS_B      2
`define PPH_PC_BUF_B     1
`define PPH_PC_INTR_B    0

`define PPH_INT_PC0      0
`define PPH_INT_PC3      1
`define PPH_EV_W         4

`endif

// File: include/pph_pkg.sv
// Types shared by the parallel port handshake block
// Offsets and field positions live in pph_defines.svh
package pph_pkg;

	typedef enum logic [1:0] {
		PPH_MODE0 = 2'b00,
		PPH_MODE1 = 2'b01,
		PPH_MODE2 = 2'b11
	} pph_mode_e;

	// Layout of a mode-set control word, bit 7 down to bit 0
	typedef struct packed {
		logic       modeset;
		logic [1:0] a_mode;
		logic       a_in;
		logic       cu_in;
		logic       b_mode;
		logic       b_in;
		logic       cl_in;
	} pph_ctrl_s;

	typedef struct packed {
		logic        sel;
		logic        en;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} pph_apb_s;

	// Field value 1x selects the bidirectional mode
	function automatic pph_mode_e pph_mode_of(input logic [1:0] f);
		if (f[1])
			return PPH_MODE2;
		else if (f[0])
			return PPH_MODE1;
		else
			return PPH_MODE0;
	endfunction : pph_mode_of

endpackage : pph_pkg

// File: hw/pph_sync.sv
// Two-flop synchroniser for a vector of pin inputs
// Assumes each bit is an independent level; no bus coherence
`timescale 1ns/1ps

module pph_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : pph_sync

// File: hw/pph_irq_reg.sv
// Sticky event status with write-one-to-clear and a mask register
// Assumes strobes are one-cycle pulses from the bus slave
`timescale 1ns/1ps

module pph_irq_reg #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] ev,
	input  wire logic         clr_we,
	input  wire logic         mask_we,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] status,
	output logic      [W-1:0] mask,
	output logic              irq
);

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			status <= '0;
		else
			status <= (status & ~(clr_we ? wdata : '0)) | ev;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			mask <= '0;
		else if (mask_we)
			mask <= wdata;
	end

	assign irq = |(status & mask);

endmodule : pph_irq_reg

// File: hw/pph_top.sv
// Parallel port handshake block: ports A, B and control/status port C
// Assumes an APB master on ref_clk; pins arrive asynchronously
//
// Function
// R1 - Software writes A0 hex to select strobed output on port A.
// R2 - Software writes 84 hex to select strobed output on port B.
// R3 - Software polls port C bit 7 before writing port A again.
// R4 - Software polls port C bit 1 before writing port B again.
// R5 - Bidirectional mode carries input and output bytes on port A alone.
// R6 - Port B stays usable in mode 0 or 1 beside bidirectional A.
// R7 - Bidirectional A with B in mode 0 frees port C bits 2-0.
// R8 - Software writes C0 hex to select bidirectional port A.
// R9 - Port C read returns the bidirectional status word layout.
// R10 - Bidirectional pins: 7 out-full, 6 ack, 5 in-full, 4 strobe, 3 irq.
// R11 - Software waits for port C bit 5 before reading port A.
// R12 - Control word with bit 7 low is a port C bit set/reset.
// R13 - Set/reset uses bits 3-1 as bit select, bit 0 as value.
// R14 - Interrupts from port C bit 0 and bit 3 enable separately.
// R15 - Mode 0 input interrupt follows the external level high and low.
// R16 - Software makes bit 0 or 3 an input for external interrupts.
// R17 - Irq bit: input enable and in-full, or output enable and empty.
// R18 - Output and input enables sit at port C bits 6 and 4.
`timescale 1ns/1ps

`include "pph_defines.svh"

module pph_top
	import pph_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  pa_in,
	output logic      [7:0]  pa_out,
	output logic      [7:0]  pa_oe_n,
	input  wire logic [7:0]  pb_in,
	output logic      [7:0]  pb_out,
	output logic      [7:0]  pb_oe_n,
	input  wire logic [7:0]  pc_in,
	output logic      [7:0]  pc_out,
	output logic      [7:0]  pc_oe_n,
	output logic             irq
);

	pph_apb_s           apb;
	pph_ctrl_s          ctrl_q;
	pph_mode_e          a_mode;
	logic [7:0]         pa_s, pb_s, pc_s, pc_p_q, pc_fall;
	logic [7:0]         pa_lat_q, pb_lat_q, pc_lat_q;
	logic [7:0]         pa_inl_q, pb_inl_q;
	logic               out_buf_full_a_n, out_buf_full_b_n;
	logic               in_buf_full_a, in_buf_full_b;
	logic [1:0]         int_en_q;
	logic [`PPH_EV_W-1:0] ev, ev_stat, ev_mask;
	logic               ev_irq;
	logic [7:0]         hs_own, hs_drv, hs_val, dir_out;
	logic [7:0]         pc_status, pa_rd, pb_rd;
	logic [31:0]        rd_val;
	logic               irq_request_a, irq_request_b;

	assign apb = {psel, penable, pwrite, paddr, pwdata};

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	pph_sync #(.W(8)) u_sync_a (
		.clk     (ref_clk),
		.reset_n (reset_n),
		.d       (pa_in),
		.q       (pa_s)
	);

	pph_sync #(.W(8)) u_sync_b (
		.clk     (ref_clk),
		.reset_n (reset_n),
		.d       (pb_in),
		.q       (pb_s)
	);

	pph_sync #(.W(8)) u_sync_c (
		.clk     (ref_clk),
		.reset_n (reset_n),
		.d       (pc_in),
		.q       (pc_s)
	);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			pc_p_q <= 8'h00; // Same as synchroniser reset: no false edge
		else
			pc_p_q <= pc_s;
	end

	assign pc_fall = ~pc_s & pc_p_q;

	////////////////////////////////////////////////////////////////////
	// APB decode; no wait state, read data registered in the setup cycle
	wire setup  = apb.sel && !apb.en;
	wire acc    = apb.sel && apb.en && pready;
	wire wr_acc = acc && apb.wr;
	wire rd_acc = acc && !apb.wr;
	wire hit_a  = apb.addr == `PPH_OFF_PORT_A;
	wire hit_b  = apb.addr == `PPH_OFF_PORT_B;
	wire hit_c  = apb.addr == `PPH_OFF_PORT_C;
	wire hit_cw = apb.addr == `PPH_OFF_CTRL;
	wire hit_ie = apb.addr == `PPH_OFF_INT_CTRL;
	wire hit_st = apb.addr == `PPH_OFF_EV_STAT;
	wire hit_mk = apb.addr == `PPH_OFF_EV_MASK;
	wire mapped = hit_a | hit_b | hit_c | hit_cw | hit_ie | hit_st | hit_mk;

	wire [7:0] wdata_lo = apb.wdata[7:0];
	wire       pa_wr    = wr_acc && hit_a;
	wire       pb_wr    = wr_acc && hit_b;
	wire       pa_rdacc = rd_acc && hit_a;
	wire       pb_rdacc = rd_acc && hit_b;
	wire       cw_wr    = wr_acc && hit_cw;
	wire       mode_wr  = cw_wr && wdata_lo[`PPH_CW_MODESET];
	wire       bsr_wr   = cw_wr && !wdata_lo[`PPH_CW_MODESET]; // R12
	wire [2:0] bsr_sel  = wdata_lo[3:1]; // R13
	wire       bsr_val  = wdata_lo[`PPH_CW_VAL];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			prdata  <= (setup && !apb.wr) ? rd_val : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control word and port latches
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			ctrl_q <= `PPH_CTRL_RST;
		else if (mode_wr)
			ctrl_q <= wdata_lo; // R1 R2 R8
	end

	assign a_mode = pph_mode_of(ctrl_q.a_mode);
	wire a_m2   = a_mode == PPH_MODE2;
	wire a_m1   = a_mode == PPH_MODE1;
	wire a_outh = a_m2 || (a_m1 && !ctrl_q.a_in); // R5
	wire a_inh  = a_m2 || (a_m1 && ctrl_q.a_in); // R5
	wire b_m1o  = ctrl_q.b_mode && !ctrl_q.b_in; // R6
	wire b_m1i  = ctrl_q.b_mode && ctrl_q.b_in; // R6

	// Strobe latches data, acknowledge empties the output buffer
	wire stb_a = a_inh && pc_fall[`PPH_PC_STB_A];
	wire ack_a = a_outh && pc_fall[`PPH_PC_ACK_A];
	wire stb_b = b_m1i && pc_fall[`PPH_PC_HS_B];
	wire ack_b = b_m1o && pc_fall[`PPH_PC_HS_B];

	// Set/reset also writes the enable bits at 6, 4 and 2
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			pc_lat_q <= 8'h00;
		else if (mode_wr)
			pc_lat_q <= 8'h00; // R12
		else if (bsr_wr)
			pc_lat_q[bsr_sel] <= bsr_val; // R13 R18
		else if (wr_acc && hit_c)
			pc_lat_q <= wdata_lo;
	end

	wire inte_out = pc_lat_q[`PPH_PC_ACK_A]; // R18
	wire inte_in  = pc_lat_q[`PPH_PC_STB_A]; // R18
	wire inte_b   = pc_lat_q[`PPH_PC_HS_B];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pa_lat_q <= 8'h00;
			pb_lat_q <= 8'h00;
		end else begin
			if (pa_wr)
				pa_lat_q <= wdata_lo;
			if (pb_wr)
				pb_lat_q <= wdata_lo; // R6
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pa_inl_q <= 8'h00;
			pb_inl_q <= 8'h00;
		end else begin
			if (stb_a)
				pa_inl_q <= pa_s; // R5
			if (stb_b)
				pb_inl_q <= pb_s;
		end
	end

	// A host write wins over a coinciding acknowledge
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_buf_full_a_n <= 1'b1;
			out_buf_full_b_n <= 1'b1;
		end else if (mode_wr) begin
			out_buf_full_a_n <= 1'b1;
			out_buf_full_b_n <= 1'b1;
		end else begin
			if (pa_wr && a_outh)
				out_buf_full_a_n <= 1'b0; // R10
			else if (ack_a)
				out_buf_full_a_n <= 1'b1; // R10
			if (pb_wr && b_m1o)
				out_buf_full_b_n <= 1'b0;
			else if (ack_b)
				out_buf_full_b_n <= 1'b1;
		end
	end

	// A strobe wins over a coinciding read
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			in_buf_full_a <= 1'b0;
			in_buf_full_b <= 1'b0;
		end else if (mode_wr) begin
			in_buf_full_a <= 1'b0;
			in_buf_full_b <= 1'b0;
		end else begin
			if (stb_a)
				in_buf_full_a <= 1'b1; // R10
			else if (pa_rdacc && a_inh)
				in_buf_full_a <= 1'b0;
			if (stb_b)
				in_buf_full_b <= 1'b1;
			else if (pb_rdacc && b_m1i)
				in_buf_full_b <= 1'b0;
		end
	end

	assign irq_request_a = (inte_in && in_buf_full_a && a_inh)
		|| (inte_out && out_buf_full_a_n && a_outh); // R17
	assign irq_request_b = ctrl_q.b_mode && inte_b
		&& (b_m1i ? in_buf_full_b : out_buf_full_b_n);

	////////////////////////////////////////////////////////////////////
	// Port C ownership: handshake bits override the general lines
	always_comb begin
		hs_own = 8'h00;
		hs_drv = 8'h00;
		hs_val = 8'h00;
		if (a_mode != PPH_MODE0) begin
			hs_own[`PPH_PC_INTR_A] = 1'b1;
			hs_drv[`PPH_PC_INTR_A] = 1'b1;
			hs_val[`PPH_PC_INTR_A] = irq_request_a; // R10
		end
		if (a_outh) begin
			hs_own[`PPH_PC_OBF_A] = 1'b1;
			hs_drv[`PPH_PC_OBF_A] = 1'b1;
			hs_val[`PPH_PC_OBF_A] = out_buf_full_a_n; // R9 R10
			hs_own[`PPH_PC_ACK_A] = 1'b1;
			hs_val[`PPH_PC_ACK_A] = inte_out; // R9
		end
		if (a_inh) begin
			hs_own[`PPH_PC_IBF_A] = 1'b1;
			hs_drv[`PPH_PC_IBF_A] = 1'b1;
			hs_val[`PPH_PC_IBF_A] = in_buf_full_a; // R9 R10
			hs_own[`PPH_PC_STB_A] = 1'b1;
			hs_val[`PPH_PC_STB_A] = inte_in; // R9
		end
		if (ctrl_q.b_mode) begin
			hs_own[2:0]            = 3'b111;
			hs_drv[1:0]            = 2'b11;
			hs_val[`PPH_PC_INTR_B] = irq_request_b;
			hs_val[`PPH_PC_BUF_B]  = b_m1i ? in_buf_full_b
				: out_buf_full_b_n;
			hs_val[`PPH_PC_HS_B]   = inte_b;
		end
	end

	assign dir_out   = {{4{!ctrl_q.cu_in}}, {4{!ctrl_q.cl_in}}}; // R7
	assign pc_status = (hs_own & hs_val)
		| (~hs_own & ((dir_out & pc_lat_q) | (~dir_out & pc_s))); // R9
	assign pa_rd = a_inh ? pa_inl_q : (ctrl_q.a_in ? pa_s : pa_lat_q);
	assign pb_rd = b_m1i ? pb_inl_q : (ctrl_q.b_in ? pb_s : pb_lat_q);

	always_comb begin
		rd_val = 32'h0;
		if (hit_a)
			rd_val = {24'h0, pa_rd};
		else if (hit_b)
			rd_val = {24'h0, pb_rd};
		else if (hit_c)
			rd_val = {24'h0, pc_status}; // R9
		else if (hit_ie)
			rd_val = {30'h0, int_en_q};
		else if (hit_st)
			rd_val = {28'h0, ev_stat};
		else if (hit_mk)
			rd_val = {28'h0, ev_mask};
	end

	////////////////////////////////////////////////////////////////////
	// Pin drivers, all registered
	// Bidirectional A drives only while the peripheral acknowledges
	wire a_drive = a_m2 ? !pc_s[`PPH_PC_ACK_A] : !ctrl_q.a_in; // R5

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pa_out  <= 8'h00;
			pa_oe_n <= 8'hff;
			pb_out  <= 8'h00;
			pb_oe_n <= 8'hff;
			pc_out  <= 8'h00;
			pc_oe_n <= 8'hff;
		end else begin
			pa_out  <= pa_lat_q;
			pa_oe_n <= {8{!a_drive}};
			pb_out  <= pb_lat_q;
			pb_oe_n <= {8{ctrl_q.b_in}};
			pc_out  <= (hs_drv & hs_val) | (~hs_own & pc_lat_q); // R10
			pc_oe_n <= ~(hs_drv | (~hs_own & dir_out)); // R7 R10
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupts: port C levels plus sticky handshake events
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			int_en_q <= 2'b00;
		else if (wr_acc && hit_ie)
			int_en_q <= wdata_lo[1:0]; // R14
	end

	assign ev = {ack_b, stb_b, ack_a, stb_a};

	pph_irq_reg #(.W(`PPH_EV_W)) u_irq (
		.clk     (ref_clk),
		.reset_n (reset_n),
		.ev      (ev),
		.clr_we  (wr_acc && hit_st),
		.mask_we (wr_acc && hit_mk),
		.wdata   (apb.wdata[`PPH_EV_W-1:0]),
		.status  (ev_stat),
		.mask    (ev_mask),
		.irq     (ev_irq)
	);

	// Level path: no latching, request drops with the pin
	wire lvl0 = int_en_q[`PPH_INT_PC0] && pc_status[0]; // R14 R15
	wire lvl3 = int_en_q[`PPH_INT_PC3] && pc_status[3]; // R14 R15

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			irq <= 1'b0;
		else
			irq <= lvl0 || lvl3 || ev_irq;
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	wire [2:0] pc_lat_lo = pc_lat_q[2:0];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	sequence s_strobe_a;
		a_m2 && pc_fall[`PPH_PC_STB_A];
	endsequence

	sequence s_in_latched;
		in_buf_full_a && (pa_inl_q == $past(pa_s));
	endsequence

	sequence s_out_written;
		pa_wr && a_outh;
	endsequence

	a_strobe_latch: assert property (s_strobe_a |=> s_in_latched) // R5
		else $error("Strobe did not latch port A input");

	a_obf_on_write: assert property (s_out_written |=> ##1 !pc_out[7]) // R10
		else $error("Output full pin did not follow port A write");

	a_mode_clears: assert property (mode_wr |=> (pc_lat_q == 8'h00)
		&& out_buf_full_a_n && !in_buf_full_a) // R12
		else $error("Mode word did not reset port C state");

	a_bsr_bit: assert property (bsr_wr
		|=> pc_lat_q[$past(bsr_sel)] == $past(bsr_val)) // R13
		else $error("Set/reset command did not reach port C bit");

	a_status_word: assert property ((setup && !apb.wr && hit_c && a_m2)
		|=> prdata[7] == $past(out_buf_full_a_n)
		&& prdata[5] == $past(in_buf_full_a)
		&& prdata[3] == $past(irq_request_a)) // R9
		else $error("Port C status word layout wrong");

	a_pin_map: assert property (a_m2 |=> pc_oe_n[6] && pc_oe_n[4]
		&& !pc_oe_n[7] && !pc_oe_n[5] && !pc_oe_n[3]) // R10
		else $error("Bidirectional port C pin directions wrong");

	a_gpio_low: assert property ((a_m2 && !ctrl_q.b_mode
		&& !ctrl_q.cl_in) |=> pc_oe_n[2:0] == 3'b000
		&& pc_out[2:0] == $past(pc_lat_lo)) // R7
		else $error("Port C low bits not free as outputs");

	a_port_b_free: assert property ((a_m2 && pb_wr)
		|=> pb_lat_q == $past(wdata_lo)) // R6
		else $error("Port B write lost in bidirectional mode");

	a_level_irq: assert property ((a_mode == PPH_MODE0 && !ctrl_q.b_mode
		&& ctrl_q.cl_in && int_en_q[0]) ##0 pc_s[0] [*2]
		|=> irq) // R15
		else $error("Level interrupt not raised from port C bit 0");

	a_irq_quiet: assert property ((int_en_q == 2'b00 && !ev_irq)
		|=> !irq) // R14
		else $error("Interrupt raised with all sources disabled");

	a_intr_m2: assert property ((a_m2 && inte_in && in_buf_full_a)
		|=> pc_out[3]) // R17
		else $error("Interrupt request bit missing for input");

	a_inte_bsr: assert property ((bsr_wr && a_m2 && bsr_sel == 3'd6)
		|=> inte_out == $past(bsr_val)) // R18
		else $error("Output interrupt enable not set by command");

endmodule : pph_top

// File: testbench/pph_periph_model.sv
// Peripheral model: strobe, ack and level lines on port C, data on port A
// Assumes its tasks are called right after a rising ref_clk edge
`timescale 1ns/1ps

module pph_periph_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] pa_out,
	input  wire logic [7:0] pa_oe_n,
	input  wire logic [7:0] pc_out,
	input  wire logic [7:0] pc_oe_n,
	output logic      [7:0] pa_in,
	output logic      [7:0] pc_in
);
	// Strobe and ack idle high, external levels idle low
	logic [7:0] a_drv = 8'h00;
	logic [7:0] c_drv = 8'h54;

	////////////////////////////////////////////////////////////////////////
	// Device wins a bit wherever it drives
	assign pa_in = (pa_oe_n & a_drv) | (~pa_oe_n & pa_out);
	assign pc_in = (pc_oe_n & c_drv) | (~pc_oe_n & pc_out);

	// One byte per ack; hold sets prompt or slow answers
	task automatic ack(input int b, input int hold, output logic [7:0] got);
		@(posedge ref_clk);
		c_drv[b] <= 1'b0;
		repeat (hold) @(posedge ref_clk);
		got = pa_in;
		c_drv[b] <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask : ack

	// Data held before and during strobe; inverse shown three cycles after release
	task automatic strobe(input logic [7:0] d, input int hold);
		@(posedge ref_clk);
		a_drv <= d;
		repeat (3) @(posedge ref_clk);
		c_drv[4] <= 1'b0;
		repeat (hold) @(posedge ref_clk);
		c_drv[4] <= 1'b1;
		repeat (3) @(posedge ref_clk);
		a_drv <= ~d;
	endtask : strobe

	task automatic level(input int b, input logic v);
		@(posedge ref_clk);
		c_drv[b] <= v;
	endtask : level

endmodule : pph_periph_model

// File: testbench/tb_parallel_port_handshake.sv
// Bench for the parallel port handshake block
// Assumes pph_top on APB and the peripheral model on its pins
`timescale 1ns/1ps
`include "pph_defines.svh"

module tb_parallel_port_handshake
	import pph_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [7:0]  pb_drv  = 8'h00;
	logic [31:0] prdata;
	logic        pready, pslverr, irq;
	logic [7:0]  pa_in, pa_out, pa_oe_n, pb_out, pb_oe_n;
	logic [7:0]  pc_in, pc_out, pc_oe_n;
	int          fail_count = 0;
	int          n_compared = 0;

	always #5 ref_clk = ~ref_clk;

	pph_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out),
		.pa_oe_n(pa_oe_n), .pb_in(pb_drv), .pb_out(pb_out),
		.pb_oe_n(pb_oe_n), .pc_in(pc_in), .pc_out(pc_out),
		.pc_oe_n(pc_oe_n), .irq(irq));

	pph_periph_model per (.ref_clk(ref_clk), .pa_out(pa_out),
		.pa_oe_n(pa_oe_n), .pc_out(pc_out), .pc_oe_n(pc_oe_n),
		.pa_in(pa_in), .pc_in(pc_in));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask : chk

	// Request held until pready is seen high at an edge, giving up after 16 edges
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rdat, output logic err);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		chk("apb pready", 32'h1, {31'h0, pready});
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		d = r[7:0];
	endtask : rd

	task automatic rchk(input string w, input logic [7:0] a,
		input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(w, {24'h0, e}, {24'h0, d});
	endtask : rchk

	task automatic poll(input int b, input logic v);
		logic [7:0] s;
		int         n;
		n = 0;
		do begin
			rd(`PPH_OFF_PORT_C, s);
			n++;
		end while (s[b] !== v && n < 50);
		chk("port c polled bit", {31'h0, v}, {31'h0, s[b]});
	endtask : poll

	task automatic wait_irq(input logic v);
		int n;
		n = 0;
		while (irq !== v && n < 12) begin
			@(posedge ref_clk);
			n++;
		end
		chk("irq level", {31'h0, v}, {31'h0, irq});
	endtask : wait_irq

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		chk("irq after reset", 32'h0, {31'h0, irq});
		chk("port a enables", 32'hff, {24'h0, pa_oe_n});
		chk("port c enables", 32'hff, {24'h0, pc_oe_n});
		apb(1'b0, `PPH_OFF_CTRL, 32'h0, r, e);
		chk("control word read", 32'h0, r);
		apb(1'b0, 8'h1c, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
	endtask : t_reset

	task automatic t_out_a(input logic [7:0] cw, input logic [7:0] d,
		input int hold);
		logic [7:0] s, got;
		wr(`PPH_OFF_CTRL, cw);
		wr(`PPH_OFF_PORT_A, d);
		rd(`PPH_OFF_PORT_C, s);
		chk("a out full status", 32'h0, {31'h0, s[7]});
		chk("a out full pin", 32'h0, {31'h0, pc_out[7]});
		per.ack(6, hold, got);
		chk("a byte taken", {24'h0, d}, {24'h0, got});
		poll(7, 1'b1);
	endtask : t_out_a

	task automatic t_out_b(input logic [7:0] cw, input logic [7:0] d);
		logic [7:0] s, got;
		wr(`PPH_OFF_CTRL, cw);
		wr(`PPH_OFF_PORT_B, d);
		@(posedge ref_clk);
		chk("b latch", {24'h0, d}, {24'h0, pb_out});
		chk("b enables", 32'h0, {24'h0, pb_oe_n});
		rd(`PPH_OFF_PORT_C, s);
		chk("b out full status", 32'h0, {31'h0, s[1]});
		per.ack(2, 4, got);
		poll(1, 1'b1);
	endtask : t_out_b

	task automatic t_mode2();
		wr(`PPH_OFF_EV_STAT, 8'h0f);
		t_out_a(8'hc0, 8'h3c, 9);
		chk("a released", 32'hff, {24'h0, pa_oe_n});
		rchk("mode 2 idle status", `PPH_OFF_PORT_C, 8'h80);
		per.strobe(8'hc5, 4);
		poll(5, 1'b1);
		chk("in full pin", 32'h1, {31'h0, pc_out[5]});
		chk("c upper dirs", 32'h0a, {27'h0, pc_oe_n[7:3]});
		rchk("a byte in", `PPH_OFF_PORT_A, 8'hc5);
		rchk("in full cleared", `PPH_OFF_PORT_C, 8'h80);
		rchk("event status", `PPH_OFF_EV_STAT, 8'h03);
		wr(`PPH_OFF_EV_MASK, 8'h01);
		wait_irq(1'b1);
		wr(`PPH_OFF_EV_STAT, 8'h03);
		wait_irq(1'b0);
		rchk("event cleared", `PPH_OFF_EV_STAT, 8'h00);
		wr(`PPH_OFF_EV_MASK, 8'h00);
	endtask : t_mode2

	task automatic t_setres();
		logic [7:0] s;
		wr(`PPH_OFF_CTRL, 8'h0d);
		rchk("out enable", `PPH_OFF_PORT_C, 8'hc8);
		wr(`PPH_OFF_CTRL, 8'h0c);
		wr(`PPH_OFF_CTRL, 8'h09);
		rchk("in enable", `PPH_OFF_PORT_C, 8'h90);
		per.strobe(8'h17, 12);
		poll(5, 1'b1);
		rchk("in request", `PPH_OFF_PORT_C, 8'hb8);
		wr(`PPH_OFF_INT_CTRL, 8'h02);
		wait_irq(1'b1);
		rchk("a byte in", `PPH_OFF_PORT_A, 8'h17);
		wait_irq(1'b0);
		wr(`PPH_OFF_INT_CTRL, 8'h00);
		wr(`PPH_OFF_CTRL, 8'h08);
		for (int b = 0; b < 3; b++) begin
			wr(`PPH_OFF_CTRL, {4'h0, b[2:0], 1'b1});
			@(posedge ref_clk);
			chk("general out", 32'h1, {31'h0, pc_out[b]});
			chk("general dir", 32'h0, {31'h0, pc_oe_n[b]});
			rd(`PPH_OFF_PORT_C, s);
			chk("general status", 32'h1, {31'h0, s[b]});
			wr(`PPH_OFF_CTRL, {4'h0, b[2:0], 1'b0});
			@(posedge ref_clk);
			chk("general cleared", 32'h0, {31'h0, pc_out[b]});
		end
	endtask : t_setres

	task automatic t_ext_irq();
		wr(`PPH_OFF_CTRL, 8'h9b);
		pb_drv <= 8'h96;
		repeat (3) @(posedge ref_clk);
		rchk("b pins in", `PPH_OFF_PORT_B, 8'h96);
		wr(`PPH_OFF_INT_CTRL, 8'h01);
		per.level(0, 1'b1);
		wait_irq(1'b1);
		per.level(0, 1'b0);
		wait_irq(1'b0);
		per.level(3, 1'b1);
		repeat (6) @(posedge ref_clk);
		chk("pc3 disabled", 32'h0, {31'h0, irq});
		wr(`PPH_OFF_INT_CTRL, 8'h02);
		wait_irq(1'b1);
		wr(`PPH_OFF_INT_CTRL, 8'h03);
		per.level(0, 1'b1);
		per.level(3, 1'b0);
		repeat (6) @(posedge ref_clk);
		chk("pc0 holds irq", 32'h1, {31'h0, irq});
		per.level(0, 1'b0);
		wait_irq(1'b0);
	endtask : t_ext_irq

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// Whole run needs a few hundred cycles
	initial begin
		#300000;
		fail_count++;
		$display("MISMATCH watchdog expected done seen timeout");
		finish_test();
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_out_a(8'ha0, 8'h69, 5);
		t_out_b(8'h84, 8'ha5);
		t_out_b(8'hc4, 8'h5a);
		t_mode2();
		t_setres();
		t_ext_irq();
		finish_test();
	end

endmodule : tb_parallel_port_handshake
